// ---- include/sst_pkg.sv ----
// Constants, configuration and status carriers for the serial slave / transmitter block.
// Assumes a single 100 MHz clock and synchronous pin inputs.
package sst_pkg;

  // Data and framing widths.
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CNT_W       = 4;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  BIT_LAST_M1 = 4'h7;

  // Divide-by-eight bit clock generator.
  localparam int unsigned DIV_W       = 3;
  localparam logic [2:0]  DIV_RESET   = 3'h0;
  localparam logic [2:0]  DIV_PRE_TOP = 3'h3;

  // Buffering in front of the transmit buffer register.
  localparam int unsigned FIFO_DEPTH  = 32;

  // Idle line levels and reset values.
  localparam logic        LINE_IDLE   = 1'b1;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // Function selection.
  typedef enum logic {
    SST_FN_SLAVE,
    SST_FN_TX
  } sst_fn_e;

  // Configuration bits that software holds steady.
  typedef struct packed {
    logic    enable;       // Block enable.
    sst_fn_e func;         // Serial slave function or asynchronous transmitter.
    logic    phase;        // Clock phase: 1 selects modes 2 and 3.
    logic    polarity;     // Idle level of the serial clock.
    logic    lsb_first;    // Bit order of the slave shifter (control bit 7).
    logic    parity_en;    // Transmitter sends a parity bit.
    logic    parity_odd;   // Odd parity when set.
    logic    aux_io_en;    // Slave select is taken from firmware.
    logic    ss_fw_n;      // Firmware slave select level, active low.
  } sst_cfg_s;

  // Status flags shown to software.
  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic complete;
    logic overrun;
  } sst_status_s;

endpackage

// ---- hw/sst_top.sv ----
// Serial slave function and asynchronous transmitter of one communication block,
// with a FIFO in front of the transmit buffer register.
// Assumes pins arrive synchronous to clock and the serial clock is far below 50 MHz.

`timescale 1ns/100ps

// Synchronous FIFO with valid/ready on both sides.
module sst_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side.
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_q < (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage array; no reset needed on the data words.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// Top of the block: slave shifter, transmitter framer and status flags.
module sst_top #(
  parameter int unsigned DEPTH = sst_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Configuration.
  input  wire sst_pkg::sst_cfg_s         cfg,
  // Transmit data from software, through the FIFO.
  input  wire logic [sst_pkg::DATA_W-1:0] wr_data,
  input  wire logic                      wr_valid,
  output logic                           wr_ready,
  // Software read strobes, one cycle each.
  input  wire logic                      rx_read,
  input  wire logic                      status_read,
  // Serial pins, synchronous to clock.
  input  wire logic                      ss_pin_n,
  input  wire logic                      sclk_in,
  input  wire logic                      mosi_in,
  output logic                           primary_out,
  output logic                           aux_out,
  output logic                           aux_oe,
  // Received data and status.
  output logic [sst_pkg::DATA_W-1:0]     rx_buffer_reg,
  output sst_pkg::sst_status_s           status,
  output logic                           tx_empty_irq
);
  import sst_pkg::*;

  typedef enum logic [2:0] {
    SST_IDLE,
    SST_START,
    SST_DATA,
    SST_PARITY,
    SST_STOP
  } sst_tx_state_e;

  // Buffers, shifter and flags.
  logic [DATA_W-1:0] tx_buffer_reg_q;
  logic [DATA_W-1:0] shift_reg_q;
  logic [DATA_W-1:0] rx_shift_q;
  logic              tx_full_q;
  logic              shift_full_q;
  logic              in_prog_q;
  logic [CNT_W-1:0]  bit_cnt_q;
  logic              rx_full_q;
  logic              complete_q;
  logic              overrun_q;
  logic              irq_armed_q;
  logic              parity_q;
  logic [DIV_W-1:0]  div_q;
  sst_tx_state_e     tx_state_q;
  logic              sclk_prev_q;
  logic              ss_prev_n_q;
  logic              complete_pend_q;

  // Drain side of the FIFO and derived events.
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_ready;
  logic              is_slave;
  logic              is_tx;
  logic              ss_n;
  logic              active;
  logic              lead;
  logic              trail;
  logic              ss_fall;
  logic              slave_load;
  logic              bit_edge;
  logic              tx_load;
  logic              tx_done;
  logic              rx_load;
  logic              ovr_hit;
  logic              first_lead;
  logic              slave_out;

  // Transmit words queue here; a stalled buffer back-pressures software.
  sst_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // Slave select source and clock edge detection.
  assign is_slave   = cfg.enable && (cfg.func == SST_FN_SLAVE);
  assign is_tx      = cfg.enable && (cfg.func == SST_FN_TX);
  assign ss_n       = cfg.aux_io_en ? cfg.ss_fw_n : ss_pin_n;
  assign active     = is_slave && !ss_n;
  assign lead       = active && (sclk_prev_q == cfg.polarity) && (sclk_in != cfg.polarity);
  assign trail      = active && (sclk_prev_q != cfg.polarity) && (sclk_in == cfg.polarity);
  assign ss_fall    = active && ss_prev_n_q;
  assign first_lead = lead && !in_prog_q;

  // Shifter load needs no transfer, an empty shifter and a full buffer.
  assign slave_load = is_slave && !in_prog_q && !shift_full_q && tx_full_q && !first_lead;
  // The bit clock rises when the divider passes from three to four.
  assign bit_edge   = is_tx && (div_q == DIV_PRE_TOP);
  assign tx_load    = bit_edge && tx_full_q
                      && ((tx_state_q == SST_IDLE) || (tx_state_q == SST_STOP));
  assign tx_done    = bit_edge && (tx_state_q == SST_STOP) && !tx_full_q;
  // Receive buffer loads on the eighth capture edge of the active phase.
  assign rx_load    = (bit_cnt_q == BIT_LAST_M1) && (cfg.phase ? trail : lead);
  // The edge before the eighth capture flags overrun while the receive buffer is still full.
  assign ovr_hit    = (bit_cnt_q == BIT_LAST_M1) && (cfg.phase ? lead : trail)
                      && rx_full_q;
  assign fifo_ready = cfg.enable && !tx_full_q;
  assign slave_out  = cfg.lsb_first ? shift_reg_q[0] : shift_reg_q[DATA_W-1];

  // Pin history; select and clock are assumed already synchronous.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
      ss_prev_n_q <= LINE_IDLE;
    end else begin
      sclk_prev_q <= sclk_in;
      ss_prev_n_q <= ss_n;
    end
  end

  // Transmit buffer register: filled from the FIFO, emptied into the shifter.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_buffer_reg_q <= BYTE_RESET;
      tx_full_q       <= 1'b0;
    end else if (!cfg.enable) begin
      tx_full_q <= 1'b0;
    end else if (fifo_valid && fifo_ready) begin
      tx_buffer_reg_q <= fifo_data;
      tx_full_q       <= 1'b1;
    end else if (slave_load || tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  // Divider is held at zero while disabled, which gates the bit clock low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= DIV_RESET;
    end else if (!is_tx) begin
      div_q <= DIV_RESET;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Slave transfer window and bit counter.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_prog_q <= 1'b0;
      bit_cnt_q <= '0;
    end else if (!active) begin
      in_prog_q <= 1'b0;
      bit_cnt_q <= '0;
    end else begin
      if (rx_load) begin
        in_prog_q <= 1'b0;
      end else if (!cfg.phase && ss_fall) begin
        in_prog_q <= 1'b1;
      end else if (first_lead) begin
        in_prog_q <= 1'b1;
      end
      if (rx_load) begin
        bit_cnt_q <= '0;
      end else if (cfg.phase ? trail : lead) begin
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  // Shared shifter: slave shifts on its output edge, transmitter on bit edges.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg_q  <= BYTE_RESET;
      shift_full_q <= 1'b0;
    end else if (!cfg.enable) begin
      shift_full_q <= 1'b0;
    end else if (slave_load || tx_load) begin
      shift_reg_q  <= tx_buffer_reg_q;
      shift_full_q <= 1'b1;
    end else if (is_slave) begin
      if (!active) begin
        shift_full_q <= shift_full_q;
      end else if (rx_load) begin
        shift_full_q <= 1'b0;
      // The trailing edge after the last capture must not disturb a freshly loaded byte.
      end else if (cfg.phase ? (lead && bit_cnt_q != '0) : (trail && in_prog_q)) begin
        shift_reg_q <= cfg.lsb_first ? {1'b0, shift_reg_q[DATA_W-1:1]}
                                     : {shift_reg_q[DATA_W-2:0], 1'b0};
      end
    end else if (bit_edge && tx_state_q == SST_DATA) begin
      shift_reg_q <= {1'b0, shift_reg_q[DATA_W-1:1]};
    end
  end

  // Receive shifter and receive buffer; buffer survives disable.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift_q    <= BYTE_RESET;
      rx_buffer_reg <= BYTE_RESET;
    end else if (cfg.phase ? trail : lead) begin
      rx_shift_q <= cfg.lsb_first ? {mosi_in, rx_shift_q[DATA_W-1:1]}
                                  : {rx_shift_q[DATA_W-2:0], mosi_in};
      if (rx_load) begin
        rx_buffer_reg <= cfg.lsb_first ? {mosi_in, rx_shift_q[DATA_W-1:1]}
                                       : {rx_shift_q[DATA_W-2:0], mosi_in};
      end
    end
  end

  // Transmitter framing sequencer; counts data bits in bit_cnt_q's place.
  logic [CNT_W-1:0] tx_cnt_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state_q <= SST_IDLE;
      tx_cnt_q   <= '0;
      parity_q   <= 1'b0;
    end else if (!is_tx) begin
      tx_state_q <= SST_IDLE;
      tx_cnt_q   <= '0;
    end else if (tx_load) begin
      tx_state_q <= SST_START;
      tx_cnt_q   <= '0;
      parity_q   <= cfg.parity_odd;
    end else if (bit_edge) begin
      unique case (tx_state_q)
        SST_IDLE:   tx_state_q <= SST_IDLE;
        SST_START:  tx_state_q <= SST_DATA;
        SST_DATA: begin
          parity_q <= parity_q ^ shift_reg_q[0];
          tx_cnt_q <= tx_cnt_q + 1'b1;
          if (tx_cnt_q == BIT_LAST_M1) begin
            tx_state_q <= cfg.parity_en ? SST_PARITY : SST_STOP;
          end
        end
        SST_PARITY: tx_state_q <= SST_STOP;
        SST_STOP:   tx_state_q <= SST_IDLE;
      endcase
    end
  end

  // Line outputs, all registered.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      primary_out <= LINE_IDLE;
      aux_out     <= LINE_IDLE;
      aux_oe      <= 1'b0;
    end else if (cfg.func == SST_FN_SLAVE) begin
      primary_out <= active ? slave_out : LINE_IDLE;
      aux_out     <= LINE_IDLE;
      aux_oe      <= 1'b0;
    end else begin
      aux_oe <= 1'b1;
      // Mode 3 clock: low in the first half of each data bit.
      aux_out <= (tx_state_q == SST_DATA) ? !div_q[DIV_W-1] : LINE_IDLE;
      unique case (tx_state_q)
        SST_IDLE:   primary_out <= LINE_IDLE;
        SST_START:  primary_out <= 1'b0;
        SST_DATA:   primary_out <= shift_reg_q[0];
        SST_PARITY: primary_out <= parity_q;
        SST_STOP:   primary_out <= LINE_IDLE;
      endcase
    end
  end

  // Sticky flags; a set in the same cycle as its clear wins.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_full_q   <= 1'b0;
      complete_q  <= 1'b0;
      overrun_q   <= 1'b0;
      irq_armed_q <= 1'b0;
    end else if (!cfg.enable) begin
      rx_full_q   <= 1'b0;
      complete_q  <= 1'b0;
      overrun_q   <= 1'b0;
      irq_armed_q <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_full_q <= 1'b1;
      end else if (rx_read) begin
        rx_full_q <= 1'b0;
      end
      // Modes 0/1 finish on the trailing half after the capture edge.
      if (tx_done || (rx_load && cfg.phase) || (!cfg.phase && trail && complete_pend_q)) begin
        complete_q <= 1'b1;
      end else if (status_read) begin
        complete_q <= 1'b0;
      end
      // Overrun has its own clear, so a read that meets a completion still clears it.
      if (ovr_hit) begin
        overrun_q <= 1'b1;
      end else if (status_read) begin
        overrun_q <= 1'b0;
      end
      if (slave_load || tx_load) begin
        irq_armed_q <= 1'b1;
      end
    end
  end

  // Marks that the next trailing edge completes a mode 0/1 byte.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      complete_pend_q <= 1'b0;
    end else if (!active || cfg.phase) begin
      complete_pend_q <= 1'b0;
    end else if (rx_load) begin
      complete_pend_q <= 1'b1;
    end else if (trail) begin
      complete_pend_q <= 1'b0;
    end
  end

  // Status outputs are registered copies of the flags.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status       <= '0;
      tx_empty_irq <= 1'b0;
    end else begin
      status.tx_empty <= cfg.enable && !tx_full_q;
      status.rx_full  <= rx_full_q;
      status.complete <= complete_q;
      status.overrun  <= overrun_q;
      tx_empty_irq    <= cfg.enable && !tx_full_q && irq_armed_q;
    end
  end

endmodule

// ---- verification/sst_top_properties.sv ----
// Port-level checker for sst_top: idle levels, select handling and disable behaviour.
// Assumes it is bound to sst_top and sees only that module's ports.
`timescale 1ns/100ps
module sst_top_properties (
  // Clock and reset.
  input wire logic                        clock,
  input wire logic                        sys_rst,
  // Watched ports.
  input wire sst_pkg::sst_cfg_s           cfg,
  input wire logic                        ss_pin_n,
  input wire logic                        primary_out,
  input wire logic                        aux_out,
  input wire logic                        aux_oe,
  input wire logic [sst_pkg::DATA_W-1:0]  rx_buffer_reg,
  input wire sst_pkg::sst_status_s        status,
  input wire logic                        tx_empty_irq
);
  import sst_pkg::*;

  // Outputs are registered, so each relation waits for its cause to stand two or three cycles.
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_slave_off_idle: assert property (
    (!cfg.enable && cfg.func == SST_FN_SLAVE)[*2] |-> primary_out)
    else $error("slave output not idle while disabled");
  a_unselected_idle: assert property (
    (cfg.func == SST_FN_SLAVE && (cfg.aux_io_en ? cfg.ss_fw_n : ss_pin_n))[*2] |-> primary_out)
    else $error("slave output driven while not selected");
  a_slave_aux_tristate: assert property (
    (cfg.func == SST_FN_SLAVE)[*2] |-> !aux_oe)
    else $error("slave auxiliary output driven");
  a_tx_aux_driven: assert property (
    (cfg.func == SST_FN_TX)[*2] |-> aux_oe)
    else $error("transmitter auxiliary clock not driven");
  a_tx_off_mark: assert property (
    (!cfg.enable && cfg.func == SST_FN_TX)[*3] |-> primary_out && aux_out)
    else $error("transmitter lines not idle while disabled");
  a_off_flags_clear: assert property (
    (!cfg.enable)[*3] |-> status == 4'h0)
    else $error("status flags set while disabled");
  a_off_no_irq: assert property (
    (!cfg.enable)[*2] |-> !tx_empty_irq)
    else $error("buffer empty interrupt while disabled");
  a_off_rx_kept: assert property (
    (!cfg.enable)[*2] |-> $stable(rx_buffer_reg))
    else $error("receive buffer changed while disabled");
endmodule

// ---- verification/sst_spi_master.sv ----
// Behavioural SPI master facing the slave function, with a half period of three cycles.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/100ps
module sst_spi_master (
  // Bench clock.
  input  wire logic clock,
  // Serial lines.
  output logic      sclk,
  output logic      mosi,
  output logic      ss_n,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  // One byte each way; select is left high when sel is clear, for firmware select.
  // The slave samples the pins on its own clock, so clocking starts only after a setup gap.
  task automatic xfer(input logic [1:0] mode, input logic lsb, input logic [7:0] tx,
                      input logic sel, output logic [7:0] rx);
    int i;
    sclk = mode[0];
    repeat (3) @(negedge clock);
    ss_n = !sel;
    repeat (3) @(negedge clock);
    for (i = 0; i < 8; i++) begin
      if (!mode[1]) begin
        mosi = lsb ? tx[i] : tx[7-i];
        repeat (3) @(negedge clock);
        rx[lsb ? i : 7-i] = miso;
        sclk = !mode[0];
        repeat (3) @(negedge clock);
        sclk = mode[0];
      end else begin
        sclk = !mode[0];
        mosi = lsb ? tx[i] : tx[7-i];
        repeat (3) @(negedge clock);
        rx[lsb ? i : 7-i] = miso;
        sclk = mode[0];
        repeat (3) @(negedge clock);
      end
    end
    repeat (3) @(negedge clock);
    ss_n = 1'b1;
    // A released line keeps no value, so show the opposite of the last bit.
    mosi = !mosi;
  endtask
endmodule

// ---- verification/test_sst_top.sv ----
// Self-checking bench for sst_top: slave transfers in all modes, select sources,
// overrun, disable, transmitter framing and FIFO fill and drain.
// Assumes the package, the design and the master model are compiled before it.
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module test_sst_top;
  import sst_pkg::*;
  typedef struct { logic [1:0] mode; logic lsb; logic [7:0] sb; logic [7:0] mb; } sst_row_s;
  localparam int unsigned DEPTH_T = 4;
  logic         clock = 1'b0;
  logic         sys_rst = 1'b1;
  sst_cfg_s     cfg;
  logic [7:0]   wr_data, rx_buffer_reg, got, n;
  logic         wr_valid, wr_ready, rx_read, status_read, primary_out, aux_out, aux_oe;
  logic         tx_empty_irq, sclk, mosi, ss_n;
  logic [10:0]  frame;
  sst_status_s  status;
  int           failures = 0, num_checks = 0, cycles = 0, i;
  sst_row_s     rows[4] = '{'{2'h0, 1'b0, 8'ha5, 8'h3c}, '{2'h1, 1'b1, 8'h81, 8'h7e},
                            '{2'h2, 1'b0, 8'h01, 8'hfe}, '{2'h3, 1'b1, 8'hc3, 8'h18}};

  sst_top #(.DEPTH(DEPTH_T)) sst_top_i (.clock(clock), .sys_rst(sys_rst), .cfg(cfg),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rx_read(rx_read),
    .status_read(status_read), .ss_pin_n(ss_n), .sclk_in(sclk), .mosi_in(mosi),
    .primary_out(primary_out), .aux_out(aux_out), .aux_oe(aux_oe),
    .rx_buffer_reg(rx_buffer_reg), .status(status), .tx_empty_irq(tx_empty_irq));
  sst_spi_master sst_spi_master_i (.clock(clock), .sclk(sclk), .mosi(mosi), .ss_n(ss_n),
    .miso(primary_out));

  // Clock and a ceiling far above the thousand or so cycles the run needs.
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      end_of_test();
    end
  end

  // Restart the slave in a new mode; the disable also clears its flags.
  task automatic setcfg(input logic [1:0] mode, input logic lsb);
    @(negedge clock);
    cfg.enable = 1'b0;
    @(negedge clock);
    cfg.phase = mode[1];
    cfg.polarity = mode[0];
    cfg.lsb_first = lsb;
    cfg.enable = 1'b1;
    repeat (3) @(negedge clock);
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge clock);
    wr_data = d;
    wr_valid = 1'b1;
    while (!wr_ready) @(negedge clock);
    @(negedge clock);
    wr_valid = 1'b0;
  endtask
  task automatic clear();
    @(negedge clock);
    rx_read = 1'b1;
    status_read = 1'b1;
    @(negedge clock);
    rx_read = 1'b0;
    status_read = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: table of slave transfers, then the hand-written cases.
  initial begin
    cfg = '0;
    cfg.ss_fw_n = 1'b1;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    rx_read = 1'b0;
    status_read = 1'b0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    `CHK(primary_out, 1'b1)
    foreach (rows[k]) begin
      setcfg(rows[k].mode, rows[k].lsb);
      push(rows[k].sb);
      repeat (3) @(negedge clock);
      sst_spi_master_i.xfer(rows[k].mode, rows[k].lsb, rows[k].mb, 1'b1, got);
      repeat (3) @(negedge clock);
      `CHK(got, rows[k].sb)
      `CHK(rx_buffer_reg, rows[k].mb)
      `CHK(status.rx_full, 1'b1)
      `CHK(status.complete, 1'b1)
      `CHK(status.overrun, 1'b0)
      `CHK(aux_oe, 1'b0)
      clear();
      `CHK(status.rx_full, 1'b0)
      `CHK(primary_out, 1'b1)
      done("slave row");
    end
    // Two bytes with no read between them.
    setcfg(2'h0, 1'b0);
    push(8'h5a);
    sst_spi_master_i.xfer(2'h0, 1'b0, 8'h11, 1'b1, got);
    sst_spi_master_i.xfer(2'h0, 1'b0, 8'h22, 1'b1, got);
    repeat (3) @(negedge clock);
    `CHK(status.overrun, 1'b1)
    `CHK(rx_buffer_reg, 8'h22)
    clear();
    `CHK(status.overrun, 1'b0)
    done("overrun");
    // Select forced low by firmware, pin left high; then firmware select negated.
    cfg.aux_io_en = 1'b1;
    cfg.ss_fw_n = 1'b0;
    setcfg(2'h0, 1'b0);
    push(8'h96);
    repeat (3) @(negedge clock);
    sst_spi_master_i.xfer(2'h0, 1'b0, 8'h69, 1'b0, got);
    repeat (3) @(negedge clock);
    `CHK(got, 8'h96)
    `CHK(rx_buffer_reg, 8'h69)
    clear();
    cfg.ss_fw_n = 1'b1;
    sst_spi_master_i.xfer(2'h0, 1'b0, 8'h0f, 1'b0, got);
    repeat (3) @(negedge clock);
    `CHK(status.rx_full, 1'b0)
    `CHK(primary_out, 1'b1)
    done("firmware select");
    // Disable keeps the receive buffer.
    cfg.enable = 1'b0;
    cfg.aux_io_en = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(status, 4'h0)
    `CHK(rx_buffer_reg, 8'h69)
    done("disable");
    // Transmitter with even parity; samples near the middle of each bit.
    cfg.func = SST_FN_TX;
    cfg.parity_en = 1'b1;
    repeat (3) @(negedge clock);
    `CHK({primary_out, aux_out}, 2'h3)
    `CHK(aux_oe, 1'b1)
    cfg.enable = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(status.tx_empty, 1'b1)
    `CHK(tx_empty_irq, 1'b0)
    push(8'hb4);
    frame = {1'b1, ^8'hb4, 8'hb4, 1'b0};
    n = 8'h00;
    while (primary_out && n < 8'd40) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    `CHK({primary_out, aux_out}, 2'h1)
    for (i = 1; i < 11; i++) begin
      repeat (6) @(negedge clock);
      if (i == 1) `CHK(aux_out, 1'b0)
      repeat (2) @(negedge clock);
      if (i == 1) `CHK(aux_out, 1'b1)
      `CHK(primary_out, frame[i])
    end
    repeat (16) @(negedge clock);
    `CHK(status.complete, 1'b1)
    `CHK(tx_empty_irq, 1'b1)
    clear();
    `CHK(status.complete, 1'b0)
    done("transmitter");
    // Fill the FIFO while disabled until it refuses, then let the transmitter drain it.
    cfg.enable = 1'b0;
    n = 8'h00;
    wr_data = 8'h3a;
    wr_valid = 1'b1;
    repeat (8) begin
      if (wr_ready) n++;
      @(negedge clock);
    end
    wr_valid = 1'b0;
    `CHK(n, 8'h04)
    cfg.enable = 1'b1;
    for (i = 0; i < 1000 && status.complete !== 1'b1; i++) @(negedge clock);
    `CHK(status.complete, 1'b1)
    `CHK(wr_ready, 1'b1)
    done("fifo");
    end_of_test();
  end
endmodule

bind sst_top sst_top_properties sst_top_properties_i (.clock(clock), .sys_rst(sys_rst),
  .cfg(cfg), .ss_pin_n(ss_pin_n), .primary_out(primary_out), .aux_out(aux_out),
  .aux_oe(aux_oe), .rx_buffer_reg(rx_buffer_reg), .status(status),
  .tx_empty_irq(tx_empty_irq));
